// *** core/rpcsc_pkg.sv ***
/*
 * Constants and types for the receiver PCS clock selection block.
 * Assumes a single system clock; the selection codes it defines are consumed
 * by the clock multiplexers and the fabric-side clock routing outside.
 */
// Functional notes
// - Non-bonded channel without rate matching clocks word aligner through deserializer write from recovered clock.
// - Rate matching on: write side and earlier use recovered; read side through deserializer write use divider.
// - Deserializer read, byte order, phase FIFO write: write clock divided by 1 or 2.
// - Without rate matching, the divided clock writing the phase compensation FIFO is also forwarded to fabric.
// - 10G receive PCS uses recovered clock normally, divider output in loopback.
// - Outside loopback the 10G receive PCS uses only recovered clock, bonded or not.
// - Receiver bonding is allowed only with rate matching enabled or with the 10G receive PCS.
// - Bonded channels take divider clock from central divider in channel 1 or 4.
// - Six-channel receive bonding needs a transmit PLL outside the channels.
// - Direct PMA mode forwards the recovered clock to fabric, bypassing the PCS.
// - Each channel forwards its transmit parallel clock to the fabric.
// - Forwarded receive clock is the divided clock without rate matching, transmit clock with it.
// - A reference clock reaches the fabric only when a transceiver channel is present.
// - A channel PLL used as transmit multiplier cannot recover clock; channel is transmit only.
// - Bonded receivers outside 10G and direct PMA mode share one forwarded receive clock from logical channel zero; FWD_RX_FROM_CH0 is also set for bonded 10G.
package rpcsc_pkg;

    // ---------------------------------------------------------------
    // Clock source codes
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        RPCSC_SRC_NONE,
        RPCSC_SRC_RECOVERED,
        RPCSC_SRC_DIVIDER,
        RPCSC_SRC_DIVIDED,
        RPCSC_SRC_FABRIC,
        RPCSC_SRC_TX_PARALLEL,
        RPCSC_SRC_REFCLK
    } rpcsc_src_e;

    // ---------------------------------------------------------------
    // Topology and reset values
    // ---------------------------------------------------------------
    localparam int RPCSC_CFG_W = 13;
    localparam logic [2:0] RPCSC_NUM_CH = 3'h6;
    localparam logic [2:0] RPCSC_CENTRAL_CH_LO = 3'h1;
    localparam logic [2:0] RPCSC_CENTRAL_CH_HI = 3'h4;
    localparam logic [2:0] RPCSC_LOGICAL_CH0 = 3'h0;
    localparam logic [2:0] RPCSC_HALF_BANK = 3'h3;
    localparam logic [1:0] RPCSC_DIV_BY_1 = 2'h1;
    localparam logic [1:0] RPCSC_DIV_BY_2 = 2'h2;
    localparam logic [RPCSC_CFG_W-1:0] RPCSC_CFG_RST = 13'h0000;
    localparam logic [2:0] RPCSC_CH_RST = 3'h0;

    // ---------------------------------------------------------------
    // Bit positions in the packed configuration word
    // ---------------------------------------------------------------
    localparam int RPCSC_B_RMF = 0;
    localparam int RPCSC_B_BOND = 1;
    localparam int RPCSC_B_TEN_G = 2;
    localparam int RPCSC_B_LPBK = 3;
    localparam int RPCSC_B_PMA_DIR = 4;
    localparam int RPCSC_B_DESER2 = 5;
    localparam int RPCSC_B_EXT_PLL = 6;
    localparam int RPCSC_B_CHPLL_TX = 7;
    localparam int RPCSC_B_XCVR = 8;
    localparam int RPCSC_B_REF_REQ = 9;
    localparam int RPCSC_B_CH_LO = 10;
    localparam int RPCSC_B_CH_HI = 12;

endpackage

// *** core/rpcsc_top.sv ***
/*
 * Receiver PCS clock selection: turns the static channel configuration into
 * a clock source code for each receive PCS stage and for the receive and transmit
 * clocks forwarded to the fabric, plus a clock enable that stands for the divided parallel clock.
 * Assumes configuration pins are asynchronous to CLK_SYS and quasi-static, and
 * that the fabric provides its own read, fixed and management clocks.
 */
`timescale 1ns/1ps

module rpcsc_top
    import rpcsc_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CFG_RATE_MATCH_EN,
    input wire logic CFG_BONDED,
    input wire logic CFG_TEN_G_PCS,
    input wire logic CFG_LOOPBACK,
    input wire logic CFG_PMA_DIRECT,
    input wire logic CFG_DESER_X2,
    input wire logic CFG_EXT_TX_PLL,
    input wire logic CFG_CH_PLL_AS_TX,
    input wire logic CFG_XCVR_PRESENT,
    input wire logic CFG_REFCLK_FWD_REQ,
    input wire logic [2:0] CFG_CHANNEL,
    input wire logic [2:0] CFG_BOND_COUNT,
    input wire logic LINK_ACTIVE,
    output rpcsc_src_e SEL_WORD_ALIGN,
    output rpcsc_src_e SEL_RMF_WR,
    output rpcsc_src_e SEL_RMF_RD,
    output rpcsc_src_e SEL_DECODER,
    output rpcsc_src_e SEL_BDS_WR,
    output rpcsc_src_e SEL_BDS_RD,
    output rpcsc_src_e SEL_BYTE_ORDER,
    output rpcsc_src_e SEL_RXPCF_WR,
    output rpcsc_src_e SEL_RXPCF_RD,
    output rpcsc_src_e SEL_TEN_G,
    output rpcsc_src_e FWD_RX_CLK,
    output rpcsc_src_e FWD_TX_CLK,
    output logic [1:0] BDS_DIV_FACTOR,
    output logic DIVIDED_CLK_EN,
    output logic [2:0] DIVIDER_CH,
    output logic FWD_RX_FROM_CH0,
    output logic FWD_REFCLK_EN,
    output logic RX_ENABLE,
    output logic CFG_INVALID,
    output logic CFG_PENDING
);

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    logic [RPCSC_CFG_W-1:0] cfg_meta_q;
    logic [RPCSC_CFG_W-1:0] cfg_sync_q;
    logic [2:0] cnt_meta_q;
    logic [2:0] cnt_sync_q;
    logic act_meta_q;
    logic act_sync_q;
    logic [RPCSC_CFG_W-1:0] cfg_raw;

    assign cfg_raw = {CFG_CHANNEL, CFG_REFCLK_FWD_REQ, CFG_XCVR_PRESENT, CFG_CH_PLL_AS_TX,
                      CFG_EXT_TX_PLL, CFG_DESER_X2, CFG_PMA_DIRECT, CFG_LOOPBACK,
                      CFG_TEN_G_PCS, CFG_BONDED, CFG_RATE_MATCH_EN};

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            cfg_meta_q <= RPCSC_CFG_RST;
            cfg_sync_q <= RPCSC_CFG_RST;
            cnt_meta_q <= RPCSC_CH_RST;
            cnt_sync_q <= RPCSC_CH_RST;
            act_meta_q <= 1'b0;
            act_sync_q <= 1'b0;
        end else begin
            cfg_meta_q <= cfg_raw;
            cfg_sync_q <= cfg_meta_q;
            cnt_meta_q <= CFG_BOND_COUNT;
            cnt_sync_q <= cnt_meta_q;
            act_meta_q <= LINK_ACTIVE;
            act_sync_q <= act_meta_q;
        end
    end

    // ---------------------------------------------------------------
    // Configuration check
    // ---------------------------------------------------------------
    logic rmf;
    logic bond;
    logic ten_g;
    logic ext_pll;
    logic [2:0] chan;
    logic cfg_bad;

    assign rmf = cfg_sync_q[RPCSC_B_RMF];
    assign bond = cfg_sync_q[RPCSC_B_BOND];
    assign ten_g = cfg_sync_q[RPCSC_B_TEN_G];
    assign ext_pll = cfg_sync_q[RPCSC_B_EXT_PLL];
    assign chan = cfg_sync_q[RPCSC_B_CH_HI:RPCSC_B_CH_LO];

    // Bonding without rate matching outside 10G, or a full-bank bond that would steal the
    // channel PLLs of the central channels, is refused outright.
    always_comb begin
        cfg_bad = 1'b0;
        if (bond && !ten_g && !rmf) begin
            cfg_bad = 1'b1;
        end
        if (bond && (cnt_sync_q == RPCSC_NUM_CH) && !ext_pll) begin
            cfg_bad = 1'b1;
        end
        if (chan >= RPCSC_NUM_CH) begin
            cfg_bad = 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Applied configuration
    // ---------------------------------------------------------------
    // A change is taken only while the channel is idle; a glitch on a clock
    // multiplexer in the middle of a frame would corrupt the datapath.
    logic [RPCSC_CFG_W-1:0] cfg_q;
    logic [2:0] cnt_q;
    logic apply;

    assign apply = !act_sync_q && !cfg_bad;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            cfg_q <= RPCSC_CFG_RST;
            cnt_q <= RPCSC_CH_RST;
        end else if (apply) begin
            cfg_q <= cfg_sync_q;
            cnt_q <= cnt_sync_q;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            CFG_INVALID <= 1'b0;
            CFG_PENDING <= 1'b0;
        end else begin
            CFG_INVALID <= cfg_bad;
            CFG_PENDING <= (cfg_sync_q != cfg_q) || (cnt_sync_q != cnt_q);
        end
    end

    // ---------------------------------------------------------------
    // Source selection from the applied configuration
    // ---------------------------------------------------------------
    logic a_rmf;
    logic a_bond;
    logic a_ten_g;
    logic a_lpbk;
    logic a_pma_dir;
    logic a_chpll_tx;
    logic [2:0] a_chan;
    rpcsc_src_e front_src;

    assign a_rmf = cfg_q[RPCSC_B_RMF];
    assign a_bond = cfg_q[RPCSC_B_BOND];
    assign a_ten_g = cfg_q[RPCSC_B_TEN_G];
    assign a_lpbk = cfg_q[RPCSC_B_LPBK];
    assign a_pma_dir = cfg_q[RPCSC_B_PMA_DIR];
    assign a_chpll_tx = cfg_q[RPCSC_B_CHPLL_TX];
    assign a_chan = cfg_q[RPCSC_B_CH_HI:RPCSC_B_CH_LO];

    // Stages behind the rate match FIFO follow the divider when it is used.
    assign front_src = a_rmf ? RPCSC_SRC_DIVIDER : RPCSC_SRC_RECOVERED;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            SEL_WORD_ALIGN <= RPCSC_SRC_NONE;
            SEL_RMF_WR <= RPCSC_SRC_NONE;
            SEL_RMF_RD <= RPCSC_SRC_NONE;
            SEL_DECODER <= RPCSC_SRC_NONE;
            SEL_BDS_WR <= RPCSC_SRC_NONE;
            SEL_BDS_RD <= RPCSC_SRC_NONE;
            SEL_BYTE_ORDER <= RPCSC_SRC_NONE;
            SEL_RXPCF_WR <= RPCSC_SRC_NONE;
            SEL_RXPCF_RD <= RPCSC_SRC_NONE;
            SEL_TEN_G <= RPCSC_SRC_NONE;
            RX_ENABLE <= 1'b0;
        end else if (a_chpll_tx || a_pma_dir) begin
            // Transmit-only channel or PCS bypass: no receive PCS stage runs.
            SEL_WORD_ALIGN <= RPCSC_SRC_NONE;
            SEL_RMF_WR <= RPCSC_SRC_NONE;
            SEL_RMF_RD <= RPCSC_SRC_NONE;
            SEL_DECODER <= RPCSC_SRC_NONE;
            SEL_BDS_WR <= RPCSC_SRC_NONE;
            SEL_BDS_RD <= RPCSC_SRC_NONE;
            SEL_BYTE_ORDER <= RPCSC_SRC_NONE;
            SEL_RXPCF_WR <= RPCSC_SRC_NONE;
            SEL_RXPCF_RD <= RPCSC_SRC_NONE;
            SEL_TEN_G <= RPCSC_SRC_NONE;
            RX_ENABLE <= !a_chpll_tx;
        end else if (a_ten_g) begin
            SEL_WORD_ALIGN <= RPCSC_SRC_NONE;
            SEL_RMF_WR <= RPCSC_SRC_NONE;
            SEL_RMF_RD <= RPCSC_SRC_NONE;
            SEL_DECODER <= RPCSC_SRC_NONE;
            SEL_BDS_WR <= RPCSC_SRC_NONE;
            SEL_BDS_RD <= RPCSC_SRC_NONE;
            SEL_BYTE_ORDER <= RPCSC_SRC_NONE;
            SEL_RXPCF_WR <= RPCSC_SRC_NONE;
            SEL_RXPCF_RD <= RPCSC_SRC_NONE;
            SEL_TEN_G <= a_lpbk ? RPCSC_SRC_DIVIDER : RPCSC_SRC_RECOVERED;
            RX_ENABLE <= 1'b1;
        end else begin
            SEL_WORD_ALIGN <= RPCSC_SRC_RECOVERED;
            SEL_RMF_WR <= a_rmf ? RPCSC_SRC_RECOVERED : RPCSC_SRC_NONE;
            SEL_RMF_RD <= a_rmf ? RPCSC_SRC_DIVIDER : RPCSC_SRC_NONE;
            SEL_DECODER <= front_src;
            SEL_BDS_WR <= front_src;
            SEL_BDS_RD <= RPCSC_SRC_DIVIDED;
            SEL_BYTE_ORDER <= RPCSC_SRC_DIVIDED;
            SEL_RXPCF_WR <= RPCSC_SRC_DIVIDED;
            SEL_RXPCF_RD <= RPCSC_SRC_FABRIC;
            SEL_TEN_G <= RPCSC_SRC_NONE;
            RX_ENABLE <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Divided parallel clock
    // ---------------------------------------------------------------
    // CLK_SYS stands in for the deserializer write clock; the divided clock
    // is represented as an enable, high every cycle or every second cycle.
    logic div_phase_q;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            div_phase_q <= 1'b0;
            DIVIDED_CLK_EN <= 1'b0;
            BDS_DIV_FACTOR <= RPCSC_DIV_BY_1;
        end else begin
            div_phase_q <= cfg_q[RPCSC_B_DESER2] ? !div_phase_q : 1'b0;
            DIVIDED_CLK_EN <= RX_ENABLE && (!cfg_q[RPCSC_B_DESER2] || div_phase_q);
            BDS_DIV_FACTOR <= cfg_q[RPCSC_B_DESER2] ? RPCSC_DIV_BY_2 : RPCSC_DIV_BY_1;
        end
    end

    // ---------------------------------------------------------------
    // Divider source and forwarded clocks
    // ---------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            DIVIDER_CH <= RPCSC_CH_RST;
            FWD_RX_FROM_CH0 <= 1'b0;
            FWD_RX_CLK <= RPCSC_SRC_NONE;
            FWD_TX_CLK <= RPCSC_SRC_NONE;
            FWD_REFCLK_EN <= 1'b0;
        end else begin
            // Bonded lanes share the central divider of their half bank.
            if (a_bond) begin
                DIVIDER_CH <= (a_chan < RPCSC_HALF_BANK) ?
                              RPCSC_CENTRAL_CH_LO : RPCSC_CENTRAL_CH_HI;
            end else begin
                DIVIDER_CH <= a_chan;
            end
            FWD_RX_FROM_CH0 <= a_bond && !a_pma_dir;
            FWD_TX_CLK <= RPCSC_SRC_TX_PARALLEL;
            if (a_pma_dir || a_ten_g) begin
                FWD_RX_CLK <= a_chpll_tx ? RPCSC_SRC_NONE : RPCSC_SRC_RECOVERED;
            end else if (a_chpll_tx) begin
                FWD_RX_CLK <= RPCSC_SRC_NONE;
            end else if (a_bond && (a_chan != RPCSC_LOGICAL_CH0)) begin
                FWD_RX_CLK <= RPCSC_SRC_NONE;
            end else begin
                // Without rate matching the forwarded clock is the one writing the phase FIFO.
                FWD_RX_CLK <= a_rmf ? RPCSC_SRC_TX_PARALLEL : RPCSC_SRC_DIVIDED;
            end
            FWD_REFCLK_EN <= cfg_q[RPCSC_B_REF_REQ] && cfg_q[RPCSC_B_XCVR];
        end
    end

endmodule

// *** test/rpcsc_monitor.sv ***
/* Port-level assertions for rpcsc_top.
   Assumes it is bound to rpcsc_top and sees only that module's ports. */
`timescale 1ns/1ps
module rpcsc_checker
    import rpcsc_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CFG_RATE_MATCH_EN,
    input wire logic CFG_BONDED,
    input wire logic CFG_TEN_G_PCS,
    input wire logic LINK_ACTIVE,
    input rpcsc_src_e SEL_WORD_ALIGN,
    input rpcsc_src_e SEL_RMF_WR,
    input rpcsc_src_e SEL_RMF_RD,
    input rpcsc_src_e SEL_DECODER,
    input rpcsc_src_e SEL_BDS_RD,
    input rpcsc_src_e SEL_RXPCF_WR,
    input rpcsc_src_e SEL_RXPCF_RD,
    input rpcsc_src_e SEL_TEN_G,
    input rpcsc_src_e FWD_RX_CLK,
    input wire logic [1:0] BDS_DIV_FACTOR,
    input wire logic DIVIDED_CLK_EN,
    input wire logic [2:0] DIVIDER_CH,
    input wire logic FWD_RX_FROM_CH0,
    input wire logic CFG_INVALID
);
    localparam rpcsc_src_e sn = RPCSC_SRC_NONE, sr = RPCSC_SRC_RECOVERED;
    localparam rpcsc_src_e sd = RPCSC_SRC_DIVIDER, sv = RPCSC_SRC_DIVIDED;
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);
    // A divided-clock tick at factor 2, with the factor still 2 one cycle on.
    sequence s_x2_tick;
        BDS_DIV_FACTOR == RPCSC_DIV_BY_2 && DIVIDED_CLK_EN ##1 BDS_DIV_FACTOR == RPCSC_DIV_BY_2;
    endsequence
    chk_norm_recovered: assert property (SEL_WORD_ALIGN == sr && SEL_RMF_RD == sn
        |-> SEL_DECODER == sr && FWD_RX_CLK == sv) else $error("recovered path wrong");
    chk_rmf_split: assert property (SEL_RMF_RD == sd
        |-> SEL_RMF_WR == sr && SEL_DECODER == sd) else $error("rate match split wrong");
    chk_divided_chain: assert property (SEL_WORD_ALIGN == sr |-> SEL_BDS_RD == sv
        && SEL_RXPCF_WR == sv && SEL_RXPCF_RD == RPCSC_SRC_FABRIC) else $error("chain wrong");
    chk_x2_alternate: assert property (s_x2_tick |-> !DIVIDED_CLK_EN)
        else $error("divided enable not alternating");
    chk_ten_g_only: assert property (SEL_TEN_G != sn
        |-> SEL_WORD_ALIGN == sn && FWD_RX_CLK == sr) else $error("10G selection wrong");
    chk_bond_needs_rmf: assert property (
        (CFG_BONDED && !CFG_RATE_MATCH_EN && !CFG_TEN_G_PCS) [*5] |-> CFG_INVALID)
        else $error("bond without rate match accepted");
    chk_bond_divider: assert property (FWD_RX_FROM_CH0
        |-> DIVIDER_CH == RPCSC_CENTRAL_CH_LO || DIVIDER_CH == RPCSC_CENTRAL_CH_HI)
        else $error("bonded divider channel wrong");
    chk_link_hold: assert property (LINK_ACTIVE [*6]
        |-> $stable(SEL_RMF_RD) && $stable(FWD_RX_CLK)) else $error("selection moved in traffic");
endmodule
bind rpcsc_top rpcsc_checker u_rpcsc_checker (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CFG_RATE_MATCH_EN(CFG_RATE_MATCH_EN),
    .CFG_BONDED(CFG_BONDED), .CFG_TEN_G_PCS(CFG_TEN_G_PCS), .LINK_ACTIVE(LINK_ACTIVE),
    .SEL_WORD_ALIGN(SEL_WORD_ALIGN), .SEL_RMF_WR(SEL_RMF_WR), .SEL_RMF_RD(SEL_RMF_RD),
    .SEL_DECODER(SEL_DECODER), .SEL_BDS_RD(SEL_BDS_RD), .SEL_RXPCF_WR(SEL_RXPCF_WR),
    .SEL_RXPCF_RD(SEL_RXPCF_RD), .SEL_TEN_G(SEL_TEN_G), .FWD_RX_CLK(FWD_RX_CLK),
    .BDS_DIV_FACTOR(BDS_DIV_FACTOR), .DIVIDED_CLK_EN(DIVIDED_CLK_EN), .DIVIDER_CH(DIVIDER_CH),
    .FWD_RX_FROM_CH0(FWD_RX_FROM_CH0), .CFG_INVALID(CFG_INVALID)
);

// *** test/rpcsc_fabric_model.sv ***
/* Fabric-side partner: consumes the forwarded receive clock and runs traffic.
   Assumes the bench raises traffic_req only once a configuration is settled. */
`timescale 1ns/1ps
module rpcsc_fabric_model
    import rpcsc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic traffic_req,
    input rpcsc_src_e fwd_rx_clk,
    input rpcsc_src_e sel_rxpcf_rd,
    output logic link_active,
    output logic fixed_clk,
    output logic mgmt_clk
);
    // The phase FIFO is read by a fabric clock locked to the forwarded one.
    // A bonded follower has no own clock and may use a core clock of its choosing.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            link_active <= 1'b0;
        end else begin
            link_active <= traffic_req &&
                (fwd_rx_clk != RPCSC_SRC_NONE || sel_rxpcf_rd == RPCSC_SRC_FABRIC);
        end
    end
    // Free-running 125 MHz and management clocks, unrelated to any channel clock.
    initial fixed_clk = 1'b0;
    initial mgmt_clk = 1'b0;
    always #4 fixed_clk = ~fixed_clk;
    always #5 mgmt_clk = ~mgmt_clk;
endmodule

// *** test/testbench.sv ***
/* Self-checking bench for rpcsc_top with the fabric partner model.
   Assumes the package, design, checker and partner are compiled before it. */
`timescale 1ns/1ps
module testbench;
    import rpcsc_pkg::*;
    localparam rpcsc_src_e sn = RPCSC_SRC_NONE, sr = RPCSC_SRC_RECOVERED, sd = RPCSC_SRC_DIVIDER;
    localparam rpcsc_src_e sv = RPCSC_SRC_DIVIDED, sf = RPCSC_SRC_FABRIC;
    localparam rpcsc_src_e st = RPCSC_SRC_TX_PARALLEL;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic traffic_req = 1'b0;
    logic [15:0] cfg = 16'h0000;
    logic link_active, div_en, from_ch0, refclk_en, rx_en, invalid, pending, prev_en;
    logic [1:0] div_factor;
    logic [2:0] divider_ch;
    rpcsc_src_e sel [10];
    rpcsc_src_e fwd_rx, fwd_tx;
    int failures = 0;
    int cmp_count = 0;
    always #2 clk_sys = ~clk_sys;
    rpcsc_top dut (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .CFG_RATE_MATCH_EN(cfg[0]), .CFG_BONDED(cfg[1]),
        .CFG_TEN_G_PCS(cfg[2]), .CFG_LOOPBACK(cfg[3]), .CFG_PMA_DIRECT(cfg[4]),
        .CFG_DESER_X2(cfg[5]), .CFG_EXT_TX_PLL(cfg[6]), .CFG_CH_PLL_AS_TX(cfg[7]),
        .CFG_XCVR_PRESENT(cfg[8]), .CFG_REFCLK_FWD_REQ(cfg[9]), .CFG_CHANNEL(cfg[12:10]),
        .CFG_BOND_COUNT(cfg[15:13]), .LINK_ACTIVE(link_active), .SEL_WORD_ALIGN(sel[0]),
        .SEL_RMF_WR(sel[1]), .SEL_RMF_RD(sel[2]), .SEL_DECODER(sel[3]), .SEL_BDS_WR(sel[4]),
        .SEL_BDS_RD(sel[5]), .SEL_BYTE_ORDER(sel[6]), .SEL_RXPCF_WR(sel[7]),
        .SEL_RXPCF_RD(sel[8]), .SEL_TEN_G(sel[9]), .FWD_RX_CLK(fwd_rx), .FWD_TX_CLK(fwd_tx),
        .BDS_DIV_FACTOR(div_factor), .DIVIDED_CLK_EN(div_en), .DIVIDER_CH(divider_ch),
        .FWD_RX_FROM_CH0(from_ch0), .FWD_REFCLK_EN(refclk_en), .RX_ENABLE(rx_en),
        .CFG_INVALID(invalid), .CFG_PENDING(pending)
    );
    rpcsc_fabric_model fabric (.clk_sys(clk_sys), .rst_n(rst_n), .traffic_req(traffic_req),
        .fwd_rx_clk(fwd_rx), .sel_rxpcf_rd(sel[8]), .link_active(link_active),
        .fixed_clk(), .mgmt_clk());
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %0h, seen %0h", name, exp, seen);
        end
    endtask
    // Configuration pins need sync, apply and output edges, so eight edges is ample.
    task automatic step(input logic [15:0] v, input rpcsc_src_e rx, input logic [2:0] dch,
        input logic [3:0] flags);
        @(posedge clk_sys);
        #1;
        cfg = v;
        repeat (8) @(posedge clk_sys);
        #1;
        check("fwd_rx", fwd_rx, rx);
        check("divider_ch", divider_ch, dch);
        check("flags", {invalid, from_ch0, refclk_en, rx_en}, flags);
    endtask
    task automatic check_sel(input rpcsc_src_e e [10]);
        for (int i = 0; i < 10; i++) begin
            check($sformatf("sel%0d", i), sel[i], e[i]);
        end
    endtask
    task automatic results();
        $display("comparisons %0d, failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #20000;
        failures++;
        results();
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        #1;
        check("sel0", sel[0], sn);
        check("div_factor", div_factor, RPCSC_DIV_BY_1);
        rst_n = 1'b1;
        step(16'h0000, sv, 3'h0, 4'h1);
        check_sel('{sr, sn, sn, sr, sr, sv, sv, sv, sf, sn});
        check("fwd_tx", fwd_tx, st);
        check("div_en", div_en, 8'h01);
        @(posedge clk_sys);
        #1;
        check("div_en", div_en, 8'h01);
        step(16'h0021, st, 3'h0, 4'h1);
        check_sel('{sr, sr, sd, sd, sd, sv, sv, sv, sf, sn});
        check("div_factor", div_factor, RPCSC_DIV_BY_2);
        prev_en = div_en;
        @(posedge clk_sys);
        #1;
        check("div_en", div_en, {7'h00, ~prev_en});
        step(16'h0004, sr, 3'h0, 4'h1);
        check_sel('{sn, sn, sn, sn, sn, sn, sn, sn, sn, sr});
        step(16'h000C, sr, 3'h0, 4'h1);
        check("sel9", sel[9], sd);
        step(16'h4806, sr, 3'h1, 4'h5);
        step(16'h4802, sr, 3'h1, 4'hD);
        step(16'h4803, sn, 3'h1, 4'h5);
        step(16'h5403, sn, 3'h4, 4'h5);
        step(16'h4003, st, 3'h1, 4'h5);
        step(16'hC003, st, 3'h1, 4'hD);
        step(16'hC043, st, 3'h1, 4'h5);
        step(16'h1800, st, 3'h1, 4'hD);
        step(16'h0010, sr, 3'h0, 4'h1);
        check("sel0", sel[0], sn);
        step(16'h0080, sn, 3'h0, 4'h0);
        step(16'h0200, sv, 3'h0, 4'h1);
        step(16'h0F00, sv, 3'h3, 4'h3);
        step(16'h0000, sv, 3'h0, 4'h1);
        traffic_req = 1'b1;
        repeat (4) @(posedge clk_sys);
        step(16'h0001, sv, 3'h0, 4'h1);
        check("pending", pending, 8'h01);
        traffic_req = 1'b0;
        step(16'h0001, st, 3'h0, 4'h1);
        check("pending", pending, 8'h00);
        results();
    end
endmodule
